/* logic/i2c_engine_defs.svh */
// Offsets, field positions, reset values and timing counts of the I2C engine
`ifndef I2C_ENGINE_DEFS_SVH
`define I2C_ENGINE_DEFS_SVH

`define I2C_ADDR_W          12
`define I2C_INT_STAT_OFFSET 12'h100
`define I2C_CTRL_OFFSET     12'h110

`define I2C_DONE_BIT        8
`define I2C_ACK_BIT         25
`define I2C_CTRL_RESET      32'h0000_0003

`define I2C_LINK_CLK_HZ     66666667
`define I2C_SLOW_RATE_HZ    99200
`define I2C_FAST_RATE_HZ    396800
`define I2C_SLOW_QTR_CYC    ((`I2C_LINK_CLK_HZ) / (4 * `I2C_SLOW_RATE_HZ))
`define I2C_FAST_QTR_CYC    ((`I2C_LINK_CLK_HZ) / (4 * `I2C_FAST_RATE_HZ))

`endif

/* logic/i2c_engine_pkg.sv */
// Types shared by the I2C engine
package i2c_engine_pkg;

	typedef struct packed {
		logic [7:0] first_tx_byte;
		logic [7:0] second_tx_byte;
		logic [7:0] third_tx_rx_byte;
		logic       hw_sw_select;
		logic       bus_rate_select;
		logic       stop_suppress;
		logic       start_suppress_single_byte;
		logic       clock_stretch_allow;
		logic       byte_count_ack_select;
		logic       clock_line_override;
		logic       data_line_override;
	} ctrl_t;

	typedef struct packed {
		logic       valid;
		logic       ack_ok;
		logic [7:0] data;
	} result_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_START,
		ST_BIT,
		ST_STOP,
		ST_FINISH
	} eng_state_t;

endpackage

/* logic/i2c_master_register_engine.sv */
// I2C master register engine: control register, status bits and bit sequencer
`timescale 1ns/1ns
`include "i2c_engine_defs.svh"

module i2c_master_register_engine
	import i2c_engine_pkg::*;
(
	input  wire logic                    clk_in,
	input  wire logic                    rst_n_in,
	input  wire logic                    link_clk_in,
	input  wire logic [`I2C_ADDR_W-1:0] reg_addr_in,
	input  wire logic                    reg_wr_in,
	input  wire logic                    reg_rd_in,
	input  wire logic [31:0]             reg_wdata_in,
	output logic      [31:0]             reg_rdata_out,
	input  wire logic                    scl_in,
	output logic                         scl_out,
	output logic                         scl_oe_out,
	input  wire logic                    sda_in,
	output logic                         sda_out,
	output logic                         sda_oe_out
);

	localparam logic [7:0] SLOW_QTR = 8'(`I2C_SLOW_QTR_CYC);
	localparam logic [7:0] FAST_QTR = 8'(`I2C_FAST_QTR_CYC);

	// Register domain
	ctrl_t       ctrl;
	logic        done_flag;
	logic        ack_status;
	logic        launch_tgl;
	logic [1:0]  scl_sync;
	logic [1:0]  sda_sync;
	logic [2:0]  done_sync;
	logic        done_evt;

	// Link domain
	logic [1:0]  link_rst_sync;
	logic        link_rst_n;
	logic [2:0]  launch_sync;
	logic [1:0]  l_scl_sync;
	logic [1:0]  l_sda_sync;
	logic [1:0]  l_scl_ovr_sync;
	logic [1:0]  l_sda_ovr_sync;
	logic [1:0]  l_mode_sync;
	logic        launch_evt;
	eng_state_t  state;
	logic [1:0]  phase;
	logic [7:0]  qtr_cnt;
	logic [7:0]  qtr_len;
	logic        stretch;
	logic        no_stop;
	logic        saved_rw;
	logic        last_is_read;
	logic        master_ack;
	logic [1:0]  byte_idx;
	logic [1:0]  last_idx;
	logic [3:0]  bit_idx;
	logic [7:0]  tx_shift;
	logic [7:0]  rx_shift;
	logic [7:0]  byte1;
	logic [7:0]  byte2;
	logic        nack_seen;
	logic        eng_scl_low;
	logic        eng_sda_low;
	logic        done_tgl;
	result_t     result;
	logic        tick;
	logic        stretch_wait;
	logic        receiving;
	logic [7:0]  following_byte;

	function automatic logic [7:0] pick_byte(input logic [1:0] idx, input logic [7:0] b1, input logic [7:0] b2);
		pick_byte = (idx == 2'd1) ? b1 : b2;
	endfunction

	assign following_byte = pick_byte(byte_idx + 2'd1, byte1, byte2);

	// Pin levels buffered into the register domain
	always_ff @(posedge clk_in) begin
		scl_sync <= {scl_sync[0], scl_in};
		sda_sync <= {sda_sync[0], sda_in};
	end

	// Completion toggle from the link domain
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			done_sync <= 3'h0;
		end else begin
			done_sync <= {done_sync[1:0], done_tgl};
		end
	end

	assign done_evt = done_sync[2] ^ done_sync[1];

	// Control register
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			ctrl       <= ctrl_t'(`I2C_CTRL_RESET);
			launch_tgl <= 1'b0;
		end else begin
			if (reg_wr_in && reg_addr_in == `I2C_CTRL_OFFSET) begin
				ctrl <= ctrl_t'(reg_wdata_in);
				if (reg_wdata_in[7]) begin
					launch_tgl <= ~launch_tgl;
				end
			end else if (done_evt && result.valid) begin
				ctrl.third_tx_rx_byte <= result.data;
			end
		end
	end

	// Status bits; completion wins over a clear in the same cycle
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			done_flag  <= 1'b0;
			ack_status <= 1'b0;
		end else begin
			if (done_evt) begin
				done_flag  <= 1'b1;
				ack_status <= result.ack_ok;
			end else if (reg_wr_in && reg_addr_in == `I2C_INT_STAT_OFFSET && reg_wdata_in[`I2C_DONE_BIT]) begin
				done_flag <= 1'b0;
			end
		end
	end

	// Read data
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			reg_rdata_out <= 32'h0000_0000;
		end else if (reg_rd_in) begin
			reg_rdata_out <= 32'h0000_0000;
			if (reg_addr_in == `I2C_CTRL_OFFSET) begin
				reg_rdata_out <= {ctrl[31:2], scl_sync[1], sda_sync[1]};
			end else if (reg_addr_in == `I2C_INT_STAT_OFFSET) begin
				reg_rdata_out[`I2C_DONE_BIT] <= done_flag;
				reg_rdata_out[`I2C_ACK_BIT]  <= ack_status;
			end
		end
	end

	// Link domain reset and synchronisers
	always_ff @(posedge link_clk_in) begin
		link_rst_sync  <= {link_rst_sync[0], rst_n_in};
		l_scl_sync     <= {l_scl_sync[0], scl_in};
		l_sda_sync     <= {l_sda_sync[0], sda_in};
		l_scl_ovr_sync <= {l_scl_ovr_sync[0], ctrl.clock_line_override};
		l_sda_ovr_sync <= {l_sda_ovr_sync[0], ctrl.data_line_override};
		l_mode_sync    <= {l_mode_sync[0], ctrl.hw_sw_select};
	end

	assign link_rst_n = link_rst_sync[1];

	always_ff @(posedge link_clk_in) begin
		if (!link_rst_n) begin
			launch_sync <= 3'h0;
		end else begin
			launch_sync <= {launch_sync[1:0], launch_tgl};
		end
	end

	assign launch_evt   = launch_sync[2] ^ launch_sync[1];
	assign tick         = (qtr_cnt == 8'h00);
	assign stretch_wait = stretch && phase == 2'd1 && !l_scl_sync[1];
	assign receiving    = last_is_read && byte_idx == last_idx;

	// Quarter-bit timer
	always_ff @(posedge link_clk_in) begin
		if (!link_rst_n) begin
			qtr_cnt <= 8'h00;
		end else if (launch_evt && state == ST_IDLE) begin
			qtr_cnt <= (ctrl.bus_rate_select ? FAST_QTR : SLOW_QTR) - 8'h01;
		end else if (state != ST_IDLE) begin
			if (tick && !stretch_wait) begin
				qtr_cnt <= qtr_len - 8'h01;
			end else if (!tick) begin
				qtr_cnt <= qtr_cnt - 8'h01;
			end
		end
	end

	// Bit sequencer
	always_ff @(posedge link_clk_in) begin
		if (!link_rst_n) begin
			state        <= ST_IDLE;
			phase        <= 2'd0;
			qtr_len      <= SLOW_QTR;
			stretch      <= 1'b0;
			no_stop      <= 1'b0;
			saved_rw     <= 1'b0;
			last_is_read <= 1'b0;
			master_ack   <= 1'b0;
			byte_idx     <= 2'd0;
			last_idx     <= 2'd0;
			bit_idx      <= 4'h0;
			tx_shift     <= 8'h00;
			rx_shift     <= 8'h00;
			byte1        <= 8'h00;
			byte2        <= 8'h00;
			nack_seen    <= 1'b0;
			eng_scl_low  <= 1'b0;
			eng_sda_low  <= 1'b0;
			done_tgl     <= 1'b0;
			result       <= '0;
		end else begin
			case (state)
				ST_IDLE: begin
					phase <= 2'd0;
					if (launch_evt) begin
						qtr_len   <= ctrl.bus_rate_select ? FAST_QTR : SLOW_QTR;
						stretch   <= ctrl.clock_stretch_allow;
						no_stop   <= ctrl.stop_suppress;
						byte1     <= ctrl.second_tx_byte;
						byte2     <= ctrl.third_tx_rx_byte;
						tx_shift  <= ctrl.first_tx_byte;
						byte_idx  <= 2'd0;
						bit_idx   <= 4'h0;
						nack_seen <= 1'b0;
						if (!ctrl.start_suppress_single_byte) begin
							saved_rw     <= ctrl.first_tx_byte[0];
							last_is_read <= ctrl.first_tx_byte[0];
							master_ack   <= 1'b0;
							if (ctrl.first_tx_byte[0]) begin
								last_idx <= 2'd1;
							end else begin
								last_idx <= ctrl.byte_count_ack_select ? 2'd2 : 2'd1;
							end
							state <= ST_START;
						end else begin
							last_is_read <= saved_rw;
							master_ack   <= ctrl.byte_count_ack_select;
							last_idx     <= 2'd0;
							eng_scl_low  <= 1'b1;
							eng_sda_low  <= saved_rw ? 1'b0 : ~ctrl.first_tx_byte[7];
							state        <= ST_BIT;
						end
					end
				end
				ST_START: begin
					if (tick && !stretch_wait) begin
						phase <= phase + 2'd1;
						case (phase)
							2'd0: eng_scl_low <= 1'b0;
							2'd1: eng_sda_low <= 1'b1;
							2'd2: eng_scl_low <= 1'b1;
							default: begin
								eng_sda_low <= ~tx_shift[7];
								state       <= ST_BIT;
							end
						endcase
					end
				end
				ST_BIT: begin
					if (tick && !stretch_wait) begin
						phase <= phase + 2'd1;
						case (phase)
							2'd0: eng_scl_low <= 1'b0;
							2'd1: begin
								if (bit_idx == 4'h8) begin
									if (!receiving) begin
										nack_seen <= l_sda_sync[1];
									end
								end else begin
									rx_shift <= {rx_shift[6:0], l_sda_sync[1]};
								end
							end
							2'd2: eng_scl_low <= 1'b1;
							default: begin
								if (bit_idx == 4'h7) begin
									bit_idx     <= 4'h8;
									eng_sda_low <= receiving & master_ack;
								end else if (bit_idx != 4'h8) begin
									bit_idx     <= bit_idx + 4'h1;
									tx_shift    <= {tx_shift[6:0], 1'b0};
									eng_sda_low <= receiving ? 1'b0 : ~tx_shift[6];
								end else if (byte_idx == last_idx || nack_seen) begin
									eng_sda_low <= ~no_stop;
									state       <= no_stop ? ST_FINISH : ST_STOP;
								end else begin
									byte_idx    <= byte_idx + 2'd1;
									bit_idx     <= 4'h0;
									tx_shift    <= following_byte;
									eng_sda_low <= (last_is_read && byte_idx + 2'd1 == last_idx) ? 1'b0 :
										~following_byte[7];
								end
							end
						endcase
					end
				end
				ST_STOP: begin
					if (tick && !stretch_wait) begin
						phase <= phase + 2'd1;
						case (phase)
							2'd0: eng_scl_low <= 1'b0;
							2'd2: eng_sda_low <= 1'b0;
							2'd3: state <= ST_FINISH;
							default: eng_sda_low <= 1'b1;
						endcase
					end
				end
				ST_FINISH: begin
					result.valid  <= last_is_read;
					result.ack_ok <= ~nack_seen;
					result.data   <= rx_shift;
					done_tgl      <= ~done_tgl;
					state         <= ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// Open-drain pin drive: software overrides or the sequencer
	always_ff @(posedge link_clk_in) begin
		if (!link_rst_n) begin
			scl_out    <= 1'b0;
			sda_out    <= 1'b0;
			scl_oe_out <= 1'b0;
			sda_oe_out <= 1'b0;
		end else begin
			scl_out    <= 1'b0;
			sda_out    <= 1'b0;
			scl_oe_out <= ~l_scl_ovr_sync[1] | (l_mode_sync[1] & eng_scl_low);
			sda_oe_out <= ~l_sda_ovr_sync[1] | (l_mode_sync[1] & eng_sda_low);
		end
	end

endmodule

/* test/i2c_engine_sva.sv */
// Port checker for the I2C master register engine
`timescale 1ns/1ns
`include "i2c_engine_defs.svh"
module i2c_engine_sva (
	input wire logic                   clk_in,
	input wire logic                   rst_n_in,
	input wire logic [`I2C_ADDR_W-1:0] reg_addr_in,
	input wire logic                   reg_wr_in,
	input wire logic                   reg_rd_in,
	input wire logic [31:0]            reg_wdata_in,
	input wire logic [31:0]            reg_rdata_out,
	input wire logic                   scl_in,
	input wire logic                   scl_oe_out,
	input wire logic                   sda_in,
	input wire logic                   sda_oe_out
);
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);
	logic       scl_q;
	logic       sda_q;
	logic [2:0] scl_age;
	logic [2:0] sda_age;
	wire        cw = reg_wr_in && reg_addr_in == `I2C_CTRL_OFFSET;
	wire        cr = reg_rd_in && reg_addr_in == `I2C_CTRL_OFFSET;
	wire [31:0] d  = reg_wdata_in;
	// Cycles each pin has held its level
	always_ff @(posedge clk_in) begin
		scl_q   <= scl_in;
		sda_q   <= sda_in;
		scl_age <= (scl_in != scl_q) ? 3'h0 : scl_age + {2'h0, scl_age != 3'h7};
		sda_age <= (sda_in != sda_q) ? 3'h0 : sda_age + {2'h0, sda_age != 3'h7};
	end
	a_scl_forced: assert property (cw && !d[1] |-> ##[1:8] scl_oe_out)
		else $error("clock not pulled");
	a_sda_forced: assert property (cw && !d[0] |-> ##[1:8] sda_oe_out)
		else $error("data not pulled");
	a_scl_readback: assert property (cr && scl_age > 3'h4 |=> reg_rdata_out[1] == $past(scl_in))
		else $error("clock bit wrong");
	a_sda_readback: assert property (cr && sda_age > 3'h4 |=> reg_rdata_out[0] == $past(sda_in))
		else $error("data bit wrong");
	a_start_issued: assert property (cw && d[7] && !d[4] && d[1:0] == 2'h3 |-> ##[1:300] sda_oe_out && !scl_oe_out)
		else $error("no start");
	a_reset_idle: assert property ($rose(rst_n_in) |-> !scl_oe_out && !sda_oe_out)
		else $error("lines pulled after reset");
	a_sw_quiet: assert property (cw && !d[7] && d[1:0] == 2'h3 |-> ##8 (!scl_oe_out && !sda_oe_out) [*8])
		else $error("lines pulled in software mode");
	a_rdata_holds: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
		else $error("read data moved");
	cover property (cw && d[7]);
	cover property (cr ##1 reg_rdata_out[15:8] != 8'h0);
	cover property (reg_rd_in ##1 reg_rdata_out[`I2C_DONE_BIT]);
endmodule

/* test/i2c_slave_model.sv */
// Behavioural I2C slave on the far side of the bus
`timescale 1ns/1ns
module i2c_slave_model (
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	input  wire logic       nack_in,
	input  wire logic       stretch_in,
	input  wire logic [7:0] rd_byte_in,
	output logic            scl_pull_out = 1'b0,
	output logic            sda_pull_out = 1'b0,
	output logic            acked_out = 1'b0,
	output logic [23:0]     rx_bytes_out = '0,
	output int              bit_per_out = 0
);
	int         bit_cnt = 0;
	int         byte_cnt = 0;
	int         t_first;
	logic [7:0] shift;
	logic       rd_mode = 1'b0;
	// Start restarts framing
	always @(negedge sda_in) if (scl_in === 1'b1) {bit_cnt, byte_cnt, rd_mode} = '0;
	always @(posedge scl_in) begin
		if (bit_cnt < 8) shift = {shift[6:0], sda_in};
		if (bit_cnt == 8) acked_out = !sda_in;
		if (bit_cnt == 1) t_first = int'($time);
		if (bit_cnt == 2) bit_per_out = int'($time) - t_first;
		bit_cnt++;
	end
	// Drive while the clock is low, optionally stretching it
	always @(negedge scl_in) begin
		if (bit_cnt == 9) begin
			// Read mode lasts until the next START, so reads without START continue
			if (byte_cnt == 0) rd_mode = shift[0];
			bit_cnt = 0;
			byte_cnt++;
		end
		if (bit_cnt == 8 && !rd_mode) begin
			rx_bytes_out = {rx_bytes_out[15:0], shift};
			sda_pull_out = !nack_in;
		end else sda_pull_out = rd_mode && bit_cnt < 8 && !rd_byte_in[7 - bit_cnt];
		if (stretch_in) begin
			scl_pull_out = 1'b1;
			#2000 scl_pull_out = 1'b0;
		end
	end
endmodule

/* test/i2c_master_register_engine_bench.sv */
// Self-checking bench for the I2C master register engine
`timescale 1ns/1ns
`include "i2c_engine_defs.svh"
module i2c_master_register_engine_bench;
	logic                   clk_in = 0;
	logic                   rst_n_in = 0;
	logic                   link_clk = 0;
	logic [`I2C_ADDR_W-1:0] addr = '0;
	logic                   wr = 0;
	logic                   rd = 0;
	logic [31:0]            wdata = '0;
	logic [31:0]            rdata;
	logic                   scl_o, scl_oe, sda_o, sda_oe, scl_pull, sda_pull, rd_seen, m_ack;
	logic [63:0]            exp_word;
	logic                   nack = 0;
	logic                   stretch = 0;
	logic [7:0]             rd_byte = '0;
	logic [23:0]            rx;
	int                     bit_per;
	logic [63:0]            expq[$];
	int                     mismatches = 0;
	int                     total_checks = 0;
	wire                    scl = (scl_oe ? scl_o : 1'b1) & !scl_pull;
	wire                    sda = (sda_oe ? sda_o : 1'b1) & !sda_pull;
	localparam logic [11:0] CT = `I2C_CTRL_OFFSET;
	localparam logic [11:0] ST = `I2C_INT_STAT_OFFSET;
	always #20 clk_in = ~clk_in;
	always begin
		#7 link_clk = 1;
		#8 link_clk = 0;
	end
	i2c_master_register_engine i2c_master_register_engine_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.link_clk_in(link_clk), .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
		.reg_rdata_out(rdata), .scl_in(scl), .scl_out(scl_o), .scl_oe_out(scl_oe), .sda_in(sda),
		.sda_out(sda_o), .sda_oe_out(sda_oe));
	i2c_slave_model i2c_slave_model_inst (.scl_in(scl), .sda_in(sda), .nack_in(nack), .stretch_in(stretch),
		.rd_byte_in(rd_byte), .scl_pull_out(scl_pull), .sda_pull_out(sda_pull), .rx_bytes_out(rx),
		.bit_per_out(bit_per), .acked_out(m_ack));
	task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr32(input logic [11:0] a, input logic [31:0] v);
		@(negedge clk_in) {addr, wr, wdata} = {a, 1'b1, v};
		@(negedge clk_in) wr = 0;
	endtask
	task automatic rd32(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		@(negedge clk_in) {addr, rd} = {a, 1'b1};
		expq.push_back({m, e & m});
		@(negedge clk_in) rd = 0;
	endtask
	task automatic launch(input logic [31:0] v, input logic ack);
		wr32(CT, v);
		for (int i = 0; i < 20000; i++) begin
			@(negedge clk_in) {addr, rd} = {ST, 1'b1};
			@(negedge clk_in) rd = 0;
			if (rdata[8] === 1'b1) break;
		end
		rd32(ST, 32'h0200_0100, {6'h0, ack, 16'h0, 1'b1, 8'h0});
		wr32(ST, 32'h100);
		rd32(ST, 32'h100, 32'h0);
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk_in) rd_seen <= rd;
	always @(negedge clk_in) begin
		if (rd_seen === 1'b1 && expq.size() > 0) begin
			exp_word = expq.pop_front();
			chk("rdata", rdata & exp_word[63:32], exp_word[31:0]);
		end
	end
	initial begin
		#2400000;
		mismatches++;
		give_verdict;
	end
	initial begin
		logic [7:0]  b0, b1, b2;
		logic [23:0] m;
		void'($urandom(32'h363c));
		repeat (10) @(negedge clk_in);
		rst_n_in = 1;
		rd32(CT, '1, 32'h3);
		rd32(12'h104, '1, '0);
		for (int k = 0; k < 4; k++) begin
			wr32(CT, k);
			repeat (8) @(negedge clk_in);
			rd32(CT, 32'h3, k);
		end
		for (int k = 0; k < 4; k++) begin
			b0 = 8'($urandom) & 8'hfe;
			b1 = 8'($urandom);
			b2 = 8'($urandom);
			stretch = k == 3;
			launch({b0, b1, b2, 1'b1, k[0], 2'b0, k == 3, k[1], 2'b11}, 1'b1);
			m = k[1] ? 24'hff_ffff : 24'h00_ffff;
			chk("bytes", rx & m, (k[1] ? {b0, b1, b2} : {8'h0, b0, b1}));
			if (k != 3) chk("period", bit_per, k[0] ? 4 * `I2C_FAST_QTR_CYC * 15 : 4 * `I2C_SLOW_QTR_CYC * 15);
		end
		stretch = 0;
		// Top bit kept high so the slave releases data after a NACK and STOP is seen
		rd_byte = 8'($urandom) | 8'h80;
		launch({b0 | 8'h01, 16'h0, 8'hc3}, 1'b1);
		rd32(CT, 32'hff00, {16'h0, rd_byte, 8'h0});
		launch({b0 | 8'h01, 16'h0, 8'he3}, 1'b1);
		rd_byte = ~rd_byte | 8'h80;
		launch({24'h0, 8'hf7}, 1'b1);
		chk("master ack", m_ack, 1);
		rd32(CT, 32'hff00, {16'h0, rd_byte, 8'h0});
		rd_byte = ~rd_byte | 8'h80;
		launch({24'h0, 8'hd3}, 1'b1);
		chk("master ack", m_ack, 0);
		rd32(CT, 32'hff00, {16'h0, rd_byte, 8'h0});
		nack = 1;
		launch({b0, 16'h0, 8'hc3}, 1'b0);
		nack = 0;
		launch({b0, b1, b2, 8'he3}, 1'b1);
		chk("scl", scl, 0);
		launch({b2, 16'h0, 8'hd7}, 1'b1);
		chk("bytes", rx[15:0], {b1, b2});
		chk("scl", scl, 1);
		give_verdict;
	end
endmodule
bind i2c_master_register_engine i2c_engine_sva i2c_engine_sva_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
	.reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
	.reg_rdata_out(reg_rdata_out), .scl_in(scl_in), .scl_oe_out(scl_oe_out), .sda_in(sda_in),
	.sda_oe_out(sda_oe_out));
